/* File: bench/tb_dual_tone_serial_readout.sv */
// Testbench for the dual-tone serial readout
`timescale 1ns/1ps
`default_nettype none
module tb_dual_tone_serial_readout;
    localparam logic [15:0] PT = 16'h0014;
    localparam logic [15:0] AT = 16'h0008;
    logic clk, nrst, tone, ack, ser_bit, steer, go, busy;
    logic [1:0] row, col;
    logic [2:0] pulses;
    logic [3:0] code;
    int n_mismatch = 0;
    int n_tests = 0;
    dual_tone_serial_readout #(.PRESENCE_TICKS(PT), .ABSENCE_TICKS(AT))
        i_dual_tone_serial_readout (.i_ref_clk(clk), .i_nrst(nrst),
        .i_tone_present(tone), .i_row_sel(row), .i_col_sel(col),
        .i_ack(ack), .o_early_steering_flag(steer),
        .o_serial_code_out(ser_bit));
    tone_host_model i_tone_host_model (.i_go(go), .i_pulses(pulses),
        .i_serial_code_out(ser_bit), .o_ack(ack), .o_code(code),
        .o_busy(busy));
    task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic guard(inout int t);
        @(negedge clk);
        t++;
        if (t > 400)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic wait_steer(logic lvl, output int cyc);
        cyc = 0;
        while (steer !== lvl)
            guard(cyc);
    endtask
    task automatic read_key(logic [2:0] n);
        int t;
        t = 0;
        @(negedge clk);
        pulses = n;
        go = 1'h1;
        @(negedge clk);
        go = 1'h0;
        while (busy === 1'h1)
            guard(t);
    endtask
    function automatic logic [3:0] key_code(logic [1:0] r, logic [1:0] c);
        if (c == 2'h3)
            return (r == 2'h3) ? 4'h0 : 4'hD + {2'h0, r};
        if (r == 2'h3)
            return (c == 2'h0) ? 4'hB : (c == 2'h1) ? 4'hA : 4'hC;
        return {r, 2'h0} - {2'h0, r} + {2'h0, c} + 4'h1;
    endfunction
    task automatic key_test(logic [1:0] r, logic [1:0] c, logic [2:0] n);
        int cyc;
        logic [3:0] exp;
        exp = key_code(r, c);
        @(negedge clk);
        row = r;
        col = c;
        tone = 1'h1;
        wait_steer(1'h1, cyc);
        check("rise", 4'(cyc >= 4 * PT && cyc <= 5 * PT + 8), 4'h1);
        read_key(n);
        check("key code", code, exp);
        check("last bit", 4'(ser_bit), 4'(exp[3]));
        check("steer held", 4'(steer), 4'h1);
        @(negedge clk);
        tone = 1'h0;
        wait_steer(1'h0, cyc);
        check("fall", 4'(cyc >= 4 * AT && cyc <= 5 * AT + 8), 4'h1);
    endtask
    task automatic t_reset();
        check("outputs", {2'h0, steer, ser_bit}, 4'h0);
        read_key(3'h4);
        check("dummy", {steer, ser_bit, code[1:0]}, 4'h0);
    endtask
    task automatic t_extra();
        key_test(2'h2, 2'h1, 3'h6);
        read_key(3'h4);
        check("late pulses", code, 4'hF);
    endtask
    task automatic t_keys();
        for (int k = 0; k < 16; k++)
            key_test(2'(k / 4), 2'(k % 4), 3'h4);
    endtask
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        nrst = 1'h1;
        tone = 1'h0;
        row = 2'h0;
        col = 2'h0;
        go = 1'h0;
        pulses = 3'h4;
        // Late reset edge: every flop process is waiting for it by now
        #1;
        nrst = 1'h0;
        repeat (8) @(negedge clk);
        nrst = 1'h1;
        t_reset();
        t_extra();
        t_keys();
        stop_test();
    end
endmodule
bind dual_tone_serial_readout tone_readout_checker #(
    .PRESENCE_TICKS(PRESENCE_TICKS), .ABSENCE_TICKS(ABSENCE_TICKS)
) i_tone_readout_checker (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_tone_present(i_tone_present), .i_ack(i_ack),
    .o_early_steering_flag(o_early_steering_flag),
    .o_serial_code_out(o_serial_code_out));
`default_nettype wire

/* File: bench/tone_host_model.sv */
// Host model: issues acknowledge pulses and collects serial code bits
`timescale 1ns/1ps
`default_nettype none
module tone_host_model #(
    parameter int HALF_NS = 200
) (
    input wire logic i_go,
    input wire logic [2:0] i_pulses,
    input wire logic i_serial_code_out,
    output logic o_ack,
    output logic [3:0] o_code,
    output logic o_busy
);
    initial
    begin
        o_ack = 1'h0;
        o_code = 4'h0;
        o_busy = 1'h0;
    end
    // Ack rests low between reads; 400 ns period, even duty
    always @(posedge i_go)
    begin
        o_busy = 1'h1;
        for (int k = 0; k < int'(i_pulses); k++)
        begin
            o_ack = 1'h1;
            #(HALF_NS);
            if (k < 4)
                o_code[k] = i_serial_code_out;
            o_ack = 1'h0;
            #(HALF_NS);
        end
        o_busy = 1'h0;
    end
endmodule
`default_nettype wire

/* File: bench/tone_readout_checker.sv */
// Port checker for the dual-tone serial readout
`timescale 1ns/1ps
`default_nettype none
module tone_readout_checker #(
    parameter logic [15:0] PRESENCE_TICKS = 16'h0014,
    parameter logic [15:0] ABSENCE_TICKS = 16'h0008
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_tone_present,
    input wire logic i_ack,
    input wire logic o_early_steering_flag,
    input wire logic o_serial_code_out
);
    // Reference tick is 4.77 clocks: bounds leave room for sync delay
    localparam int HI_MIN = 4 * int'(PRESENCE_TICKS);
    localparam int HI_MAX = 5 * int'(PRESENCE_TICKS) + 8;
    localparam int LO_MIN = 4 * int'(ABSENCE_TICKS);
    localparam int LO_MAX = 5 * int'(ABSENCE_TICKS) + 8;
    int hi_r, hi_nxt, lo_r, lo_nxt;
    logic [2:0] pul_r, pul_nxt;
    logic ack_d_r, steer_d_r;
    always_comb
    begin
        hi_nxt = i_tone_present ? hi_r + 1 : 0;
        lo_nxt = i_tone_present ? 0 : lo_r + 1;
        pul_nxt = pul_r;
        if (o_early_steering_flag && !steer_d_r)
            pul_nxt = 3'h0;
        else if (i_ack && !ack_d_r && pul_r != 3'h7)
            pul_nxt = pul_r + 3'h1;
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            hi_r <= 0;
            lo_r <= 0;
            pul_r <= 3'h0;
            ack_d_r <= 1'h0;
            steer_d_r <= 1'h0;
        end
        else
        begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            pul_r <= pul_nxt;
            ack_d_r <= i_ack;
            steer_d_r <= o_early_steering_flag;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence steer_up;
        !o_early_steering_flag ##1 o_early_steering_flag;
    endsequence
    sequence steer_down;
        o_early_steering_flag ##1 !o_early_steering_flag;
    endsequence
    reset_clear_a: assert property (disable iff (1'h0)
        !i_nrst |-> !o_early_steering_flag && !o_serial_code_out)
        else $error("outputs not clear in reset");
    rise_early_a: assert property (steer_up |-> hi_r >= HI_MIN)
        else $error("steering rose too early");
    rise_late_a: assert property (
        hi_r == HI_MAX |-> o_early_steering_flag)
        else $error("steering rose too late");
    fall_early_a: assert property (steer_down |-> lo_r >= LO_MIN)
        else $error("steering fell too early");
    fall_late_a: assert property (
        lo_r == LO_MAX |-> !o_early_steering_flag)
        else $error("steering fell too late");
    steer_hold_a: assert property (
        o_early_steering_flag && i_tone_present
        |=> o_early_steering_flag) else $error("steering dropped with tone");
    bit_timing_a: assert property ($changed(o_serial_code_out)
        |-> $past(i_ack, 2) && !$past(i_ack, 5))
        else $error("serial bit moved without pulse");
    bit_limit_a: assert property ($changed(o_serial_code_out)
        |-> pul_r inside {[3'h1:3'h4]}) else $error("extra pulse shifted");
endmodule
`default_nettype wire

/* File: hw/code_fifo.sv */
// Two-entry code buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module code_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [PW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [PW:0] count_r, count_nxt;
    logic [WIDTH-1:0] out_data_r, out_data_nxt;
    logic push, pop;

    // Room for a word whenever fewer than DEPTH are held, empty included
    assign o_in_ready = (count_r < (PW+1)'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data = out_data_r;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    always_comb
    begin
        mem_nxt = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (push)
        begin
            mem_nxt[wr_ptr_r] = i_in_data;
            wr_ptr_nxt = bump(wr_ptr_r);
        end
        if (pop)
        begin
            rd_ptr_nxt = bump(rd_ptr_r);
        end
        if (push && !pop)
        begin
            count_nxt = (PW+1)'(count_r + 1'b1);
        end
        else if (pop && !push)
        begin
            count_nxt = (PW+1)'(count_r - 1'b1);
        end
        // Head word registered so the consumer sees a flop output
        if (count_nxt == '0)
        begin
            out_data_nxt = out_data_r;
        end
        else if (count_r == '0 || (pop && count_r == (PW+1)'(1)))
        begin
            out_data_nxt = i_in_data;
        end
        else
        begin
            out_data_nxt = mem_nxt[rd_ptr_nxt];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_r[i] <= '0;
            end
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            out_data_r <= '0;
        end
        else
        begin
            mem_r <= mem_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            out_data_r <= out_data_nxt;
        end
    end

endmodule
`default_nettype wire

/* File: hw/dual_tone_serial_readout.sv */
// Tone-pair qualifier, key coder and acknowledge-driven serial readout
`timescale 1ns/1ps
`default_nettype none
`include "tone_readout_consts.svh"

module dual_tone_serial_readout #(
    parameter logic [15:0] PRESENCE_TICKS = 16'(`PRESENCE_TICKS),
    parameter logic [15:0] ABSENCE_TICKS = 16'(`ABSENCE_TICKS)
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_tone_present,
    input wire logic [1:0] i_row_sel,
    input wire logic [1:0] i_col_sel,
    input wire logic i_ack,
    output logic o_early_steering_flag,
    output logic o_serial_code_out
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [`SYNC_BITS-1:0] sync1_r, sync2_r;
    logic tone_s, ack_s, ack_prev_r;
    logic [1:0] row_s, col_s;

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            ack_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {i_ack, i_tone_present, i_row_sel, i_col_sel};
            sync2_r <= sync1_r;
            ack_prev_r <= ack_s;
        end
    end

    assign {ack_s, tone_s, row_s, col_s} = sync2_r;

    logic ack_rise;
    assign ack_rise = ack_s && !ack_prev_r;

    // ----------------------------------------------------------------
    // Reference tick, 4.194304 MHz enable from the system clock
    // ----------------------------------------------------------------
    // Fractional accumulator: average rate exact, jitter one clock
    logic [`PHASE_BITS-1:0] phase_r, phase_nxt;
    logic ref_tick;
    logic [`PHASE_BITS:0] phase_sum;

    always_comb
    begin
        phase_sum = {1'b0, phase_r} + (`PHASE_BITS+1)'(`REF_CLK_HZ);
        ref_tick = (phase_sum >= (`PHASE_BITS+1)'(`SYS_CLK_HZ));
        if (ref_tick)
        begin
            phase_nxt = `PHASE_BITS'(phase_sum -
                (`PHASE_BITS+1)'(`SYS_CLK_HZ));
        end
        else
        begin
            phase_nxt = `PHASE_BITS'(phase_sum);
        end
    end

    // ----------------------------------------------------------------
    // Key coder
    // ----------------------------------------------------------------
    function automatic tone_readout_pkg::key_code_t key_code(
        input logic [1:0] row,
        input logic [1:0] col
    );
        case ({row, col})
            4'h0: key_code = 4'h1;
            4'h1: key_code = 4'h2;
            4'h2: key_code = 4'h3;
            4'h4: key_code = 4'h4;
            4'h5: key_code = 4'h5;
            4'h6: key_code = 4'h6;
            4'h8: key_code = 4'h7;
            4'h9: key_code = 4'h8;
            4'hA: key_code = 4'h9;
            4'hD: key_code = 4'hA;
            4'hC: key_code = 4'hB;
            4'hE: key_code = 4'hC;
            4'h3: key_code = 4'hD;
            4'h7: key_code = 4'hE;
            4'hB: key_code = 4'hF;
            default: key_code = 4'h0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Steering qualifier
    // ----------------------------------------------------------------
    logic steer_r, steer_nxt;
    logic [`TICK_CNT_BITS-1:0] tick_cnt_r, tick_cnt_nxt;
    logic push_valid, push_ready;
    tone_readout_pkg::key_code_t push_code;

    assign push_code = key_code(row_s, col_s);

    always_comb
    begin
        steer_nxt = steer_r;
        tick_cnt_nxt = tick_cnt_r;
        push_valid = 1'b0;
        if (steer_r == tone_s)
        begin
            tick_cnt_nxt = '0;
        end
        // Saturates so a long wait on a full buffer cannot wrap the count
        else if (ref_tick && tick_cnt_r != '1)
        begin
            tick_cnt_nxt = `TICK_CNT_BITS'(tick_cnt_r + 1'b1);
        end
        if (!steer_r && tone_s && tick_cnt_r >= PRESENCE_TICKS)
        begin
            // Full buffer holds the flag low so no key is dropped
            push_valid = 1'b1;
            if (push_ready)
            begin
                steer_nxt = 1'b1;
                tick_cnt_nxt = '0;
            end
        end
        else if (steer_r && !tone_s && tick_cnt_r >= ABSENCE_TICKS)
        begin
            steer_nxt = 1'b0;
            tick_cnt_nxt = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            phase_r <= '0;
            steer_r <= 1'b0;
            tick_cnt_r <= '0;
        end
        else
        begin
            phase_r <= phase_nxt;
            steer_r <= steer_nxt;
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    assign o_early_steering_flag = steer_r;

    // ----------------------------------------------------------------
    // Code buffer between coder and serialiser
    // ----------------------------------------------------------------
    logic pop_valid, pop_ready;
    tone_readout_pkg::key_code_t pop_code;

    code_fifo #(
        .WIDTH(`CODE_BITS),
        .DEPTH(`FIFO_DEPTH)
    ) i_code_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_in_valid(push_valid),
        .o_in_ready(push_ready),
        .i_in_data(push_code),
        .o_out_valid(pop_valid),
        .i_out_ready(pop_ready),
        .o_out_data(pop_code)
    );

    // ----------------------------------------------------------------
    // Serialiser
    // ----------------------------------------------------------------
    tone_readout_pkg::ser_state_t ser_state_r, ser_state_nxt;
    tone_readout_pkg::key_code_t shift_r, shift_nxt;
    logic [1:0] bit_idx_r, bit_idx_nxt;
    logic ser_bit_r, ser_bit_nxt;
    logic armed_r, armed_nxt;

    // Armed by each new steering rise; cleared once a code is taken
    assign pop_ready = (ser_state_r != tone_readout_pkg::SER_SHIFT) &&
        ack_rise && steer_r && armed_r;

    always_comb
    begin
        ser_state_nxt = ser_state_r;
        shift_nxt = shift_r;
        bit_idx_nxt = bit_idx_r;
        ser_bit_nxt = ser_bit_r;
        armed_nxt = armed_r;
        if (steer_nxt && !steer_r)
        begin
            armed_nxt = 1'b1;
        end
        case (ser_state_r)
            tone_readout_pkg::SER_IDLE, tone_readout_pkg::SER_DONE:
            begin
                if (pop_ready && pop_valid)
                begin
                    shift_nxt = pop_code;
                    ser_bit_nxt = pop_code[0];
                    bit_idx_nxt = 2'h1;
                    armed_nxt = 1'b0;
                    ser_state_nxt = tone_readout_pkg::SER_SHIFT;
                end
            end
            tone_readout_pkg::SER_SHIFT:
            begin
                // A short burst leaves us here: next key reads stale bits
                if (ack_rise)
                begin
                    ser_bit_nxt = shift_r[bit_idx_r];
                    bit_idx_nxt = 2'(bit_idx_r + 1'b1);
                    if (bit_idx_r == `CODE_LAST_BIT)
                    begin
                        ser_state_nxt = tone_readout_pkg::SER_DONE;
                    end
                end
            end
            default:
            begin
                ser_state_nxt = tone_readout_pkg::SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ser_state_r <= tone_readout_pkg::SER_IDLE;
            shift_r <= '0;
            bit_idx_r <= '0;
            ser_bit_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            ser_state_r <= ser_state_nxt;
            shift_r <= shift_nxt;
            bit_idx_r <= bit_idx_nxt;
            ser_bit_r <= ser_bit_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign o_serial_code_out = ser_bit_r;

endmodule
`default_nettype wire

/* File: hw/tone_readout_consts.svh */
// Offsets-free constant set: timing and field figures for the tone readout
`ifndef TONE_READOUT_CONSTS_SVH
`define TONE_READOUT_CONSTS_SVH

// ----------------------------------------------------------------
// Clocks
// ----------------------------------------------------------------
`define SYS_CLK_HZ 64'd20000000
`define REF_CLK_HZ 64'd4194304

// ----------------------------------------------------------------
// Detection times, in microseconds
// ----------------------------------------------------------------
`define PRESENCE_DETECT_TIME_US 64'd12000
`define ABSENCE_DETECT_TIME_US 64'd5000
`define US_PER_S 64'd1000000

// Reference ticks per detection time, rounded down
`define PRESENCE_TICKS \
    (`PRESENCE_DETECT_TIME_US * `REF_CLK_HZ / `US_PER_S)
`define ABSENCE_TICKS \
    (`ABSENCE_DETECT_TIME_US * `REF_CLK_HZ / `US_PER_S)

// ----------------------------------------------------------------
// Field sizes
// ----------------------------------------------------------------
`define CODE_BITS 4
`define CODE_LAST_BIT 2'h3
`define TICK_CNT_BITS 16
`define PHASE_BITS 25
`define FIFO_DEPTH 2
`define SYNC_BITS 6

`endif

/* File: hw/tone_readout_pkg.sv */
// Types shared by the tone readout design
package tone_readout_pkg;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SHIFT = 2'b01,
        SER_DONE = 2'b11
    } ser_state_t;

    typedef logic [3:0] key_code_t;

endpackage
